// >>> rtl/dpsb_device.sv
// device end: owns strobe/mask and read data, follows the host's chip select
// functional notes at head; assumes the host keeps its side of the turnarounds
`timescale 1ns/1ps
module dpsb_device (
  input  wire logic       core_clk,
  input  wire logic       rst,
  dpsb_if.dev             bus,
  input  wire logic       extended_latency,
  input  wire logic [7:0] rd_data,
  output logic            wr_valid,
  output logic [7:0]      wr_data,
  output logic            wr_byte_en,
  output logic            rd_req,
  output logic            clock_stop,
  output logic            power_down,
  output logic [15:0]     config_reg0
);

  // ---------------------------------------------------------------
  // phase tracking
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_CA, ST_RD_LAT, ST_WR_LAT, ST_RD_DATA, ST_WR_DATA, ST_PDOWN, ST_DUMMY
  } dpsb_dst_e;

  dpsb_dst_e                st_q;
  logic [dpsb_pkg::CNT_W-1:0] cnt_q;
  logic [dpsb_pkg::CNT_W-1:0] stop_cnt_q;
  logic                     clk_prev_q;
  logic [47:0]              ca_q;
  logic                     ext_q;
  logic                     edge_w;
  logic                     cs_act;
  logic                     cmd_read;
  logic                     cmd_reg;
  logic [dpsb_pkg::CNT_W-1:0] lat_w;

  assign edge_w   = bus.bus_clock != clk_prev_q;
  assign cs_act   = !bus.chip_select_n && bus.reset_n;
  assign cmd_read = ca_q[47];
  assign cmd_reg  = ca_q[46];
  // doubled latency when refresh collides with the transaction
  assign lat_w    = ext_q ? dpsb_pkg::CNT_W'(4 * dpsb_pkg::LAT_CYCLES)
                          : dpsb_pkg::CNT_W'(2 * dpsb_pkg::LAT_CYCLES);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= bus.bus_clock;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      ca_q <= '0;
      ext_q <= 1'b0;
      config_reg0 <= dpsb_pkg::CFG0_RESET;
      power_down <= 1'b0;
    end else if (!bus.reset_n) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      config_reg0 <= dpsb_pkg::CFG0_RESET;
      power_down <= 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (!bus.chip_select_n) begin
            st_q <= ST_CA;
            cnt_q <= '0;
            ext_q <= extended_latency;
          end
        end
        ST_CA: begin
          if (bus.chip_select_n) begin
            st_q <= ST_IDLE;
          end else if (edge_w) begin
            ca_q <= {ca_q[39:0], bus.data_bus};
            if (cnt_q == dpsb_pkg::CNT_W'(dpsb_pkg::CA_BYTES - 1)) begin
              cnt_q <= '0;
              if (ca_q[39]) begin
                st_q <= ST_RD_LAT;
              end else if (ca_q[38]) begin
                st_q <= ST_WR_DATA;
              end else begin
                st_q <= ST_WR_LAT;
              end
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
        end
        ST_RD_LAT, ST_WR_LAT: begin
          if (bus.chip_select_n) begin
            st_q <= ST_IDLE;
          end else if (edge_w) begin
            if (cnt_q == lat_w - 1'b1) begin
              cnt_q <= '0;
              st_q <= (st_q == ST_RD_LAT) ? ST_RD_DATA : ST_WR_DATA;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
        end
        ST_RD_DATA: begin
          if (bus.chip_select_n) begin
            st_q <= ST_IDLE;
          end
        end
        ST_WR_DATA: begin
          if (bus.chip_select_n) begin
            st_q <= ST_IDLE;
          end else if (cmd_reg && edge_w) begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == '0) begin
              config_reg0[15:8] <= bus.data_bus;
            end else if (cnt_q == dpsb_pkg::CNT_W'(1)) begin
              config_reg0[7:0] <= bus.data_bus;
            end
          end
        end
        ST_PDOWN: begin
          // only chip select is watched; the low-then-high pair is a dummy
          if (!bus.chip_select_n) begin
            st_q <= ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          if (bus.chip_select_n) begin
            st_q <= ST_IDLE;
            config_reg0 <= dpsb_pkg::CFG0_RESET;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
      // entry on the closing edge of a config write with bit 15 cleared
      if (st_q == ST_WR_DATA && bus.chip_select_n && cmd_reg
          && !config_reg0[dpsb_pkg::PDOWN_BIT]) begin
        st_q <= ST_PDOWN;
      end
      power_down <= (st_q == ST_PDOWN) || (st_q == ST_DUMMY);
    end
  end

  // ---------------------------------------------------------------
  // clock stop detection
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stop_cnt_q <= '0;
      clock_stop <= 1'b0;
    end else if (!cs_act || edge_w || st_q != ST_RD_DATA && st_q != ST_WR_DATA) begin
      stop_cnt_q <= '0;
      clock_stop <= 1'b0;
    end else if (stop_cnt_q != dpsb_pkg::CNT_W'(dpsb_pkg::STOP_CYCLES)) begin
      stop_cnt_q <= stop_cnt_q + 1'b1;
    end else begin
      clock_stop <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus.dev_data_oe_n <= 1'b1;
      bus.dev_dsm_oe_n  <= 1'b1;
      bus.dev_dsm_o     <= 1'b0;
      bus.dev_data_o    <= 8'h00;
      rd_req            <= 1'b0;
    end else begin
      bus.dev_data_oe_n <= 1'b1;
      bus.dev_dsm_oe_n  <= 1'b1;
      bus.dev_dsm_o     <= 1'b0;
      rd_req            <= 1'b0;
      if (cs_act) begin
        unique case (st_q)
          ST_IDLE, ST_CA: begin
            bus.dev_dsm_oe_n <= 1'b0;
            bus.dev_dsm_o    <= ext_q | (st_q == ST_IDLE && extended_latency);
          end
          ST_DUMMY: begin
            // wake-up access still sees a plain latency flag; data stays released
            bus.dev_dsm_oe_n <= 1'b0;
          end
          ST_RD_LAT: begin
            bus.dev_dsm_oe_n <= 1'b0;
          end
          ST_RD_DATA: begin
            // data is held while the clock is parked
            bus.dev_data_oe_n <= 1'b0;
            bus.dev_dsm_oe_n  <= 1'b0;
            if (edge_w) begin
              bus.dev_data_o <= rd_data;
              bus.dev_dsm_o  <= bus.bus_clock;
              rd_req         <= 1'b1;
            end else begin
              bus.dev_dsm_o  <= clk_prev_q;
            end
          end
          ST_WR_DATA: begin
            // zero-latency writes keep the strobe low, never released mid-burst
            bus.dev_dsm_oe_n <= !cmd_reg;
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_valid   <= 1'b0;
      wr_data    <= 8'h00;
      wr_byte_en <= 1'b0;
    end else begin
      wr_valid <= cs_act && st_q == ST_WR_DATA && edge_w && !cmd_reg;
      wr_data  <= bus.data_bus;
      wr_byte_en <= cmd_reg ? 1'b1 : !bus.data_strobe_mask;
    end
  end

endmodule : dpsb_device

// >>> rtl/dpsb_pkg.sv
// shared constants and types for the ddr pseudo-static memory bus ends
// assumes a single 250 mhz core clock on both ends
package dpsb_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS    = 4000;
  localparam int ACC_TIME_NS      = 35;
  localparam int STOP_MARGIN_NS   = 30;
  localparam int STOP_CYCLES      = ((ACC_TIME_NS + STOP_MARGIN_NS) * 1000 + CLK_PERIOD_PS - 1)
                                    / CLK_PERIOD_PS;
  localparam int CSM_TIME_NS      = 4000;
  localparam int CSM_CYCLES       = (CSM_TIME_NS * 1000) / CLK_PERIOD_PS;

  // ---------------------------------------------------------------
  // bus phases and widths
  // ---------------------------------------------------------------
  localparam int CA_BYTES         = 6;
  localparam int LAT_CYCLES       = 6;
  localparam int CNT_W            = 12;
  localparam int PDOWN_BIT        = 15;
  localparam logic [15:0] CFG0_RESET = 16'h8f1f;

  typedef enum logic [1:0] {
    DPSB_READ,
    DPSB_WRITE,
    DPSB_WRITE_ZL
  } dpsb_kind_e;

endpackage : dpsb_pkg

// >>> rtl/dpsb_if.sv
// link between memory host and memory device: ddr byte bus with shared strobe/mask
// both ends run on core_clk; bus_clock is a sampled level, not a clock
`timescale 1ns/1ps
interface dpsb_if;
  logic       chip_select_n;
  logic       bus_clock;
  logic       bus_clock_complement;
  logic       reset_n;
  logic [7:0] host_data_o;
  logic       host_data_oe_n;
  logic       host_dsm_o;
  logic       host_dsm_oe_n;
  logic [7:0] dev_data_o;
  logic       dev_data_oe_n;
  logic       dev_dsm_o;
  logic       dev_dsm_oe_n;
  logic [7:0] data_bus;
  logic       data_strobe_mask;

  // resolved wire levels; undriven bus reads as zero
  assign data_bus = !host_data_oe_n ? host_data_o :
                    (!dev_data_oe_n ? dev_data_o : 8'h00);
  assign data_strobe_mask = !host_dsm_oe_n ? host_dsm_o :
                            (!dev_dsm_oe_n ? dev_dsm_o : 1'b0);

  modport host (output chip_select_n, bus_clock, bus_clock_complement, reset_n,
                output host_data_o, host_data_oe_n, host_dsm_o, host_dsm_oe_n,
                input  data_bus, data_strobe_mask);
  modport dev  (input  chip_select_n, bus_clock, bus_clock_complement, reset_n,
                output dev_data_o, dev_data_oe_n, dev_dsm_o, dev_dsm_oe_n,
                input  data_bus, data_strobe_mask);
endinterface : dpsb_if

// >>> rtl/dpsb_host.sv
// host end: drives chip select, bus clock, command-address and write data
// assumes the device follows the interface phase table
`timescale 1ns/1ps
module dpsb_host (
  input  wire logic       core_clk,
  input  wire logic       rst,
  dpsb_if.host            bus,
  input  wire logic       start,
  input  wire logic [47:0] cmd_addr,
  input  wire logic [7:0] wr_byte,
  input  wire logic       wr_mask,
  input  wire logic       pause,
  input  wire logic [7:0] length,
  output logic            busy,
  output logic            rd_valid,
  output logic [7:0]      rd_byte
);

  typedef enum logic [2:0] {H_IDLE, H_CA, H_LAT, H_DATA, H_END} dpsb_hst_e;

  dpsb_hst_e                  st_q;
  logic [dpsb_pkg::CNT_W-1:0] cnt_q;
  logic [dpsb_pkg::CNT_W-1:0] csm_q;
  logic [47:0]                ca_q;
  logic                       ext_q;
  logic                       zl;
  logic                       rd;
  logic                       pause_w;
  logic [dpsb_pkg::CNT_W-1:0] lat_end;

  assign rd = ca_q[47];
  // a pause waits for the clock to be low, so the parked pair is always idle
  assign pause_w = pause && !bus.bus_clock;
  // writes start one edge early (device samples next edge), reads one late
  assign lat_end = (ext_q ? dpsb_pkg::CNT_W'(4 * dpsb_pkg::LAT_CYCLES)
                          : dpsb_pkg::CNT_W'(2 * dpsb_pkg::LAT_CYCLES))
                   + (rd ? dpsb_pkg::CNT_W'(1) : {dpsb_pkg::CNT_W{1'b1}});
  assign zl = !ca_q[47] && ca_q[46];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= H_IDLE;
      cnt_q <= '0;
      csm_q <= '0;
      ca_q <= '0;
      ext_q <= 1'b0;
      busy <= 1'b0;
      rd_valid <= 1'b0;
      rd_byte <= 8'h00;
      bus.chip_select_n <= 1'b1;
      bus.bus_clock <= 1'b0;
      bus.bus_clock_complement <= 1'b1;
      bus.reset_n <= 1'b0;
      bus.host_data_o <= 8'h00;
      bus.host_data_oe_n <= 1'b1;
      bus.host_dsm_o <= 1'b0;
      bus.host_dsm_oe_n <= 1'b1;
    end else begin
      bus.reset_n <= 1'b1;
      rd_valid <= 1'b0;
      csm_q <= bus.chip_select_n ? '0 : csm_q + 1'b1;
      // toggle only in the CA, latency and data phases, and not while a data-phase pause holds; parked level is low/high
      if (st_q != H_IDLE && st_q != H_END && !(pause_w && st_q == H_DATA)) begin
        bus.bus_clock <= !bus.bus_clock;
        bus.bus_clock_complement <= bus.bus_clock;
      end else if (!bus.bus_clock) begin
        bus.bus_clock_complement <= 1'b1;
      end
      unique case (st_q)
        H_IDLE: begin
          busy <= 1'b0;
          if (start) begin
            ca_q <= cmd_addr;
            busy <= 1'b1;
            cnt_q <= '0;
            bus.chip_select_n <= 1'b0;
            st_q <= H_CA;
          end
        end
        H_CA: begin
          bus.host_data_oe_n <= 1'b0;
          bus.host_data_o <= ca_q[47:40];
          ca_q <= {ca_q[39:0], ca_q[47:40]};
          ext_q <= bus.data_strobe_mask;
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == dpsb_pkg::CNT_W'(dpsb_pkg::CA_BYTES - 1)) begin
            cnt_q <= '0;
            // the command byte has rotated down to [39:32] by now
            st_q <= (!ca_q[39] && ca_q[38]) ? H_DATA : H_LAT;
          end
        end
        H_LAT: begin
          bus.host_data_oe_n <= 1'b1;
          bus.host_dsm_oe_n <= 1'b1;
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == lat_end) begin
            cnt_q <= '0;
            st_q <= H_DATA;
          end
        end
        H_DATA: begin
          bus.host_data_oe_n <= rd;
          bus.host_dsm_oe_n <= rd || zl;
          bus.host_data_o <= wr_byte;
          bus.host_dsm_o <= wr_mask;
          if (!pause_w) begin
            cnt_q <= cnt_q + 1'b1;
            if (rd) begin
              rd_valid <= 1'b1;
              rd_byte <= bus.data_bus;
            end
          end
          if ((!pause_w && cnt_q + 1'b1 == dpsb_pkg::CNT_W'(length))
              || csm_q >= dpsb_pkg::CNT_W'(dpsb_pkg::CSM_CYCLES - 2)) begin
            st_q <= H_END;
          end
        end
        H_END: begin
          bus.chip_select_n <= 1'b1;
          bus.host_data_oe_n <= 1'b1;
          bus.host_dsm_oe_n <= 1'b1;
          bus.bus_clock <= 1'b0;
          bus.bus_clock_complement <= 1'b1;
          st_q <= H_IDLE;
        end
        default: begin
          st_q <= H_IDLE;
        end
      endcase
    end
  end

endmodule : dpsb_host

// >>> bench/dpsb_assertions.sv
// checker for the link between host and device ends of the ddr memory bus
// sees the interface signals as plain inputs, instantiated beside the interface
`timescale 1ns/1ps
module dpsb_assertions (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       chip_select_n,
  input wire logic       bus_clock,
  input wire logic       bus_clock_complement,
  input wire logic       reset_n,
  input wire logic       host_data_oe_n,
  input wire logic       host_dsm_oe_n,
  input wire logic [7:0] dev_data_o,
  input wire logic       dev_data_oe_n,
  input wire logic       dev_dsm_o,
  input wire logic       dev_dsm_oe_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // chip select low time, counted in core clocks
  // ---------------------------------------------------------------
  logic [dpsb_pkg::CNT_W-1:0] cs_low_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) cs_low_q <= '0;
    else if (chip_select_n) cs_low_q <= '0;
    else cs_low_q <= cs_low_q + 12'h001;
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  sequence ca_start;
    $fell(chip_select_n);
  endsequence
  sequence strobe_held;
    (!dev_dsm_oe_n)[*4];
  endsequence
  sequence read_turn;
    $rose(host_data_oe_n) && !chip_select_n ##2 (!dev_dsm_oe_n && dev_data_oe_n);
  endsequence

  a_reset_bus_off: assert property (!reset_n |-> dev_data_oe_n && dev_dsm_oe_n)
    else $error("device drives bus while held in reset");
  a_standby_bus_off: assert property (chip_select_n && $past(chip_select_n) |->
    dev_data_oe_n && dev_dsm_oe_n)
    else $error("device drives bus while deselected");
  a_ca_strobe_on: assert property (ca_start |-> ##2 strobe_held)
    else $error("latency flag not driven in command phase");
  a_read_turn_low: assert property (read_turn |-> !dev_dsm_o)
    else $error("strobe not low in read turnaround");
  a_data_turn_gap: assert property ($fell(dev_data_oe_n) |-> $past(host_data_oe_n))
    else $error("device drives data before host released it");
  a_no_contend: assert property (!(!host_data_oe_n && !dev_data_oe_n) &&
    !(!host_dsm_oe_n && !dev_dsm_oe_n))
    else $error("both ends drive one line");
  a_dsm_turn_gap: assert property ($fell(host_dsm_oe_n) |->
    $past(dev_dsm_oe_n) && dev_dsm_oe_n)
    else $error("strobe changed owner without a gap");
  a_clock_pair: assert property (bus_clock_complement != bus_clock)
    else $error("clock pair not complementary");
  a_park_idle: assert property ((!chip_select_n && $stable(bus_clock))[*3] |-> !bus_clock)
    else $error("stopped clock not parked low");
  a_stop_data_hold: assert property ((!dev_data_oe_n && $stable(bus_clock))[*3] |->
    $stable(dev_data_o))
    else $error("read data moved while clock stopped");
  a_cs_low_bound: assert property (cs_low_q < dpsb_pkg::CSM_CYCLES)
    else $error("chip select low too long");
endmodule // dpsb_assertions

// >>> bench/ddr_psram_bus_state_control_tb.sv
// self-checking bench: host end and device end joined by the bus interface
// assumes one 250 mhz core clock; random traffic from a fixed seed
`timescale 1ns/1ps
module ddr_psram_bus_state_control_tb;
  logic        core_clk, rst, start, wr_mask, pause, extended_latency;
  logic [47:0] cmd_addr;
  logic [7:0]  wr_byte, length, rd_data, rd_byte, wr_data, cur_b;
  logic        busy, rd_valid, wr_valid, wr_byte_en, rd_req, clock_stop, power_down;
  logic [15:0] config_reg0;
  logic        cur_en, zl_on, skip_chk;
  int          num_errors, n_checks, wr_cnt, rd_cnt;

  dpsb_if bus_if();
  dpsb_host dpsb_host_i (.core_clk(core_clk), .rst(rst), .bus(bus_if), .start(start),
    .cmd_addr(cmd_addr), .wr_byte(wr_byte), .wr_mask(wr_mask), .pause(pause),
    .length(length), .busy(busy), .rd_valid(rd_valid), .rd_byte(rd_byte));
  dpsb_device dpsb_device_i (.core_clk(core_clk), .rst(rst), .bus(bus_if),
    .extended_latency(extended_latency), .rd_data(rd_data), .wr_valid(wr_valid),
    .wr_data(wr_data), .wr_byte_en(wr_byte_en), .rd_req(rd_req), .clock_stop(clock_stop),
    .power_down(power_down), .config_reg0(config_reg0));
  dpsb_assertions dpsb_assertions_i (.core_clk(core_clk), .rst(rst),
    .chip_select_n(bus_if.chip_select_n), .bus_clock(bus_if.bus_clock),
    .bus_clock_complement(bus_if.bus_clock_complement), .reset_n(bus_if.reset_n),
    .host_data_oe_n(bus_if.host_data_oe_n), .host_dsm_oe_n(bus_if.host_dsm_oe_n),
    .dev_data_o(bus_if.dev_data_o), .dev_data_oe_n(bus_if.dev_data_oe_n),
    .dev_dsm_o(bus_if.dev_dsm_o), .dev_dsm_oe_n(bus_if.dev_dsm_oe_n));

  // ---------------------------------------------------------------
  // comparisons and verdict
  // ---------------------------------------------------------------
  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: flag got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: byte got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: word got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // a zero-latency write has no mask, so every byte counts as enabled
  function automatic logic exp_en(input logic m, input logic zl);
    return zl | ~m;
  endfunction

  // ---------------------------------------------------------------
  // clock, watchdog, monitors
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    num_errors++;
    test_done();
  end
  always @(posedge core_clk) begin
    if (!rst && wr_valid && !skip_chk) begin
      wr_cnt++;
      chk8(wr_data, cur_b);
      chk1(wr_byte_en, cur_en);
    end
    if (!rst && rd_valid && !skip_chk) begin
      rd_cnt++;
      chk8(rd_byte, cur_b);
    end
    if (zl_on) chk1(bus_if.host_dsm_oe_n, 1'b1);
  end

  // ---------------------------------------------------------------
  // one transaction, waited out under a bound
  // ---------------------------------------------------------------
  task automatic run(input logic rd, input logic zl, input logic [7:0] b, input logic m,
                     input logic [7:0] len, input logic ps);
    int i;
    @(posedge core_clk);
    cur_b = b;
    cur_en = exp_en(m, zl);
    zl_on = zl;
    wr_cnt = 0;
    rd_cnt = 0;
    cmd_addr <= {rd, zl, zl ? 46'h0 : {14'h0, 32'($urandom)}};
    wr_byte <= b;
    rd_data <= b;
    wr_mask <= m;
    length <= len;
    extended_latency <= 1'($urandom);
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    for (i = 0; i < 3000 && (i < 2 || busy !== 1'b0); i++) begin
      @(posedge core_clk);
      if (ps && i == 40) pause <= 1'b1;
      if (ps && i == 72) begin
        chk1(clock_stop, 1'b1);
        pause <= 1'b0;
      end
    end
    if (i == 3000) chk1(busy, 1'b0);
    zl_on = 1'b0;
    repeat (2) @(posedge core_clk);
    if (!zl && !skip_chk) chk8(rd ? rd_cnt[7:0] : wr_cnt[7:0], len);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {start, wr_mask, pause, extended_latency, cmd_addr, wr_byte, length, rd_data} = '0;
    {cur_b, cur_en, zl_on, skip_chk, num_errors, n_checks, wr_cnt, rd_cnt} = '0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk1(bus_if.chip_select_n, 1'b1);
    chk1(bus_if.dev_data_oe_n, 1'b1);
    chk1(bus_if.dev_dsm_oe_n, 1'b1);
    chk16(config_reg0, dpsb_pkg::CFG0_RESET);
    void'($urandom(21332));
    run(1'b0, 1'b0, 8'ha5, 1'b0, 8'h01, 1'b0);
    run(1'b1, 1'b0, 8'h3c, 1'b0, 8'h40, 1'b1);
    run(1'b0, 1'b0, 8'h96, 1'b1, 8'hff, 1'b0);
    repeat (12) run(1'($urandom), 1'b0, 8'($urandom), 1'($urandom), 8'(1 + $urandom % 16), 1'b0);
    run(1'b0, 1'b1, 8'hc3, 1'b1, 8'h02, 1'b0);
    chk16(config_reg0, 16'hc3c3);
    run(1'b0, 1'b1, 8'h4e, 1'b0, 8'h02, 1'b0);
    chk1(power_down, 1'b1);
    chk1(bus_if.dev_data_oe_n, 1'b1);
    chk1(bus_if.dev_dsm_oe_n, 1'b1);
    // the wake-up access is a dummy: no data is exchanged, so its bytes are not judged
    skip_chk = 1'b1;
    run(1'b1, 1'b0, 8'h11, 1'b0, 8'h04, 1'b0);
    skip_chk = 1'b0;
    chk1(power_down, 1'b0);
    chk16(config_reg0, dpsb_pkg::CFG0_RESET);
    run(1'b1, 1'b0, 8'h5a, 1'b0, 8'h03, 1'b0);
    test_done();
  end
endmodule // ddr_psram_bus_state_control_tb
